/* core/flash_host_consts.vh */
/*
 * Constants for the parallel flash host controller: clock rate, strobe
 * timing, erase durations, command words, operation codes.
 * Assumes a 125 MHz system clock and a flash used in 16-bit word mode.
 */
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH

// ****************************************************************
// Clock
// ****************************************************************
`define CLK_PERIOD_NS     8
`define CLK_HZ            125000000
// Least time in ns to whole cycles, rounded up, never below one
`define NS2CYC(ns)        ((((ns)+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS) < 1 ? \
	1 : (((ns)+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS))

// ****************************************************************
// Strobe timing in ns, synchroniser margin in cycles
// ****************************************************************
`define T_AS_NS           10
`define T_WP_NS           100
`define T_ACC_NS          120
`define T_WPH_ERASE_NS    150
`define T_OEHP_NS         150
`define SYNC_MARGIN_CYC   3

// ****************************************************************
// Erase durations
// ****************************************************************
`define T_EC_S            10
`define T_SEC_MS          200

// ****************************************************************
// Command words and addresses
// ****************************************************************
`define ADDR_UNLOCK1      19'h05555
`define ADDR_UNLOCK2      19'h02AAA
`define DATA_UNLOCK1      16'h00AA
`define DATA_UNLOCK2      16'h0055
`define DATA_ERASE_SETUP  16'h0080
`define DATA_CHIP_ERASE   16'h0010
`define DATA_SECTOR_ERASE 16'h0030
`define DATA_ID_ENTRY     16'h0090
`define DATA_ID_EXIT      16'h00F0

// ****************************************************************
// Operation codes on the command port
// ****************************************************************
`define OP_CHIP_ERASE     3'h0
`define OP_SECTOR_ERASE   3'h1
`define OP_ID_READ        3'h2
`define OP_ID_EXIT        3'h3
`define OP_ARRAY_READ     3'h4

// ****************************************************************
// Status bit positions
// ****************************************************************
`define BIT_POLL          7
`define BIT_TOGGLE        6
`define BIT_SUSP_TOGGLE   2

`endif

/* core/flash_bus_cycle.v */
/*
 * One flash bus cycle, read or write, on the chip-select, output-enable
 * and write strobes with the required setup, pulse and recovery times.
 * Assumes a single clock domain; the data pins come from outside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"

module flash_bus_cycle (
	input  wire        clk,
	input  wire        reset,
	input  wire        start,
	input  wire        is_write,
	input  wire [18:0] addr,
	input  wire [15:0] wdata,
	output wire        idle,
	output reg         done_reg,
	output reg  [15:0] rdata_reg,
	output reg  [18:0] flash_addr_reg,
	output reg  [15:0] flash_dq_out_reg,
	output reg         flash_dq_oe_reg,
	input  wire [15:0] flash_dq_in,
	output reg         flash_ce_n_reg,
	output reg         flash_oe_n_reg,
	output reg         flash_we_n_reg
);

	// ****************************************************************
	// Cycle counts
	// ****************************************************************
	localparam integer SETUP_I = `NS2CYC(`T_AS_NS);
	localparam integer WP_I    = `NS2CYC(`T_WP_NS);
	localparam integer ACC_I   = `NS2CYC(`T_ACC_NS) + `SYNC_MARGIN_CYC;
	localparam integer HIGH_I  = `NS2CYC(`T_OEHP_NS);
	localparam [4:0] SETUP_CYC = SETUP_I[4:0];
	localparam [4:0] WP_CYC    = WP_I[4:0];
	localparam [4:0] ACC_CYC   = ACC_I[4:0];
	localparam [4:0] HIGH_CYC  = HIGH_I[4:0];

	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_SETUP = 3'h1;
	localparam [2:0] S_WRITE = 3'h2;
	localparam [2:0] S_READ  = 3'h3;
	localparam [2:0] S_SAMP  = 3'h4;
	localparam [2:0] S_RECOV = 3'h5;

	reg [2:0]  state_reg;    // Cycle phase
	reg [4:0]  cnt_reg;      // Phase countdown
	reg        write_reg;    // Cycle is a write
	reg [15:0] dq_s1_reg;    // Pin synchroniser stage 1
	reg [15:0] dq_s2_reg;    // Pin synchroniser stage 2
	reg [15:0] dq_s3_reg;    // Pin synchroniser stage 3

	assign idle = (state_reg == S_IDLE);

	// ****************************************************************
	// Data pin synchroniser
	// ****************************************************************
	always @(posedge clk) begin
		dq_s1_reg <= flash_dq_in;
		dq_s2_reg <= dq_s1_reg;
		dq_s3_reg <= dq_s2_reg;
	end

	// ****************************************************************
	// Strobe sequencer
	// ****************************************************************
	always @(posedge clk) begin
		if (reset) begin
			state_reg        <= S_IDLE;
			cnt_reg          <= 5'h00;
			write_reg        <= 1'b0;
			done_reg         <= 1'b0;
			rdata_reg        <= 16'h0000;
			flash_addr_reg   <= 19'h00000;
			flash_dq_out_reg <= 16'h0000;
			flash_dq_oe_reg  <= 1'b0;
			flash_ce_n_reg   <= 1'b1;
			flash_oe_n_reg   <= 1'b1;
			flash_we_n_reg   <= 1'b1;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				// Latch address and data, drop chip select
				if (start) begin
					write_reg        <= is_write;
					flash_addr_reg   <= addr;
					flash_dq_out_reg <= wdata;
					flash_dq_oe_reg  <= is_write;
					flash_ce_n_reg   <= 1'b0;
					cnt_reg          <= SETUP_CYC;
					state_reg        <= S_SETUP;
				end
			end
			S_SETUP: begin
				// Address setup, then the chosen strobe falls
				if (cnt_reg == 5'h01) begin
					if (write_reg) begin
						flash_we_n_reg <= 1'b0;
						cnt_reg        <= WP_CYC;
						state_reg      <= S_WRITE;
					end else begin
						flash_oe_n_reg <= 1'b0;
						cnt_reg        <= ACC_CYC;
						state_reg      <= S_READ;
					end
				end else begin
					cnt_reg <= cnt_reg - 5'h01;
				end
			end
			S_WRITE: begin
				// Write pulse; output enable stays high throughout
				if (cnt_reg == 5'h01) begin
					flash_we_n_reg <= 1'b1;
					flash_ce_n_reg <= 1'b1;
					cnt_reg        <= HIGH_CYC;
					state_reg      <= S_RECOV;
				end else begin
					cnt_reg <= cnt_reg - 5'h01;
				end
			end
			S_READ: begin
				// Access time plus synchroniser latency
				if (cnt_reg == 5'h01)
					state_reg <= S_SAMP;
				else
					cnt_reg <= cnt_reg - 5'h01;
			end
			S_SAMP: begin
				// Take the word once two stages agree
				if (dq_s2_reg == dq_s3_reg) begin
					rdata_reg      <= dq_s3_reg;
					flash_oe_n_reg <= 1'b1;
					flash_ce_n_reg <= 1'b1;
					cnt_reg        <= HIGH_CYC;
					state_reg      <= S_RECOV;
				end
			end
			S_RECOV: begin
				// Strobes high at least 150 ns before the next cycle
				if (cnt_reg == 5'h01) begin
					flash_dq_oe_reg <= 1'b0;
					done_reg        <= 1'b1;
					state_reg       <= S_IDLE;
				end else begin
					cnt_reg <= cnt_reg - 5'h01;
				end
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

endmodule // flash_bus_cycle
`default_nettype wire

/* core/flash_erase_host.v */
/*
 * Host controller for a dual-plane parallel flash: issues chip and
 * sector erase commands, detects the end of erase by toggle polling,
 * enters, reads and leaves product identification, and reads the array.
 * Assumes a flash in word mode wired to the flash_* pins, one clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"

module flash_erase_host #(
	parameter [30:0] CHIP_ERASE_MAX_CYC   = `T_EC_S * `CLK_HZ,
	parameter [30:0] SECTOR_ERASE_NOM_CYC = `T_SEC_MS * (`CLK_HZ / 1000)
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        cmd_valid,
	output wire        cmd_ready,
	input  wire [2:0]  cmd_op,
	input  wire [18:0] cmd_addr,
	output reg         done_reg,
	output reg  [15:0] result_reg,
	output reg         timeout_reg,
	output wire [18:0] flash_addr,
	output wire [15:0] flash_dq_out,
	output wire        flash_dq_oe,
	input  wire [15:0] flash_dq_in,
	output wire        flash_ce_n,
	output wire        flash_oe_n,
	output wire        flash_we_n
);

	// ****************************************************************
	// States and counts
	// ****************************************************************
	localparam [2:0] M_IDLE   = 3'h0;
	localparam [2:0] M_WRITE  = 3'h1;
	localparam [2:0] M_WWAIT  = 3'h2;
	localparam [2:0] M_NOM    = 3'h3;
	localparam [2:0] M_READ   = 3'h4;
	localparam [2:0] M_RWAIT  = 3'h5;
	localparam [2:0] M_FIN    = 3'h6;

	reg [2:0]  state_reg;     // Controller state
	reg [2:0]  op_reg;        // Operation in progress
	reg [18:0] addr_reg;      // Command address, also polling address
	reg [2:0]  step_reg;      // Command write step
	reg        first_reg;     // Next poll read is the first
	reg [15:0] prev_reg;      // Previous poll read
	reg [30:0] timer_reg;     // Erase elapsed cycles
	reg        eng_start;     // Start one bus cycle
	reg        eng_write;     // Bus cycle direction
	reg [34:0] step_word;     // Current step address and data
	wire       eng_idle;      // Bus engine free
	wire       eng_done;      // Bus cycle finished
	wire [15:0] eng_rdata;    // Word read by the engine

	// ****************************************************************
	// Command step table
	// ****************************************************************
	// Returns number of write steps for an operation
	function [2:0] step_count;
		input [2:0] op;
		begin
			case (op)
			`OP_CHIP_ERASE:   step_count = 3'h6;
			`OP_SECTOR_ERASE: step_count = 3'h6;
			`OP_ID_READ:      step_count = 3'h3;
			`OP_ID_EXIT:      step_count = 3'h3;
			default:          step_count = 3'h0;
			endcase
		end
	endfunction

	// Address and data of one write step
	always @* begin
		step_word = {`ADDR_UNLOCK1, `DATA_UNLOCK1};
		case (step_reg)
		3'h0: step_word = {`ADDR_UNLOCK1, `DATA_UNLOCK1};
		3'h1: step_word = {`ADDR_UNLOCK2, `DATA_UNLOCK2};
		3'h2: begin
			// Third step names the operation
			if (op_reg == `OP_ID_READ)
				step_word = {`ADDR_UNLOCK1, `DATA_ID_ENTRY};
			else if (op_reg == `OP_ID_EXIT)
				step_word = {`ADDR_UNLOCK1, `DATA_ID_EXIT};
			else
				step_word = {`ADDR_UNLOCK1, `DATA_ERASE_SETUP};
		end
		3'h3: step_word = {`ADDR_UNLOCK1, `DATA_UNLOCK1};
		3'h4: step_word = {`ADDR_UNLOCK2, `DATA_UNLOCK2};
		3'h5: begin
			// Final erase cycle
			if (op_reg == `OP_CHIP_ERASE)
				step_word = {`ADDR_UNLOCK1, `DATA_CHIP_ERASE};
			else
				step_word = {addr_reg, `DATA_SECTOR_ERASE};
		end
		default: step_word = {`ADDR_UNLOCK1, `DATA_UNLOCK1};
		endcase
	end

	assign cmd_ready = (state_reg == M_IDLE);

	// ****************************************************************
	// Controller
	// ****************************************************************
	always @(posedge clk) begin
		if (reset) begin
			state_reg   <= M_IDLE;
			op_reg      <= `OP_ARRAY_READ;
			addr_reg    <= 19'h00000;
			step_reg    <= 3'h0;
			first_reg   <= 1'b1;
			prev_reg    <= 16'h0000;
			timer_reg   <= 31'h00000000;
			eng_start   <= 1'b0;
			eng_write   <= 1'b0;
			done_reg    <= 1'b0;
			result_reg  <= 16'h0000;
			timeout_reg <= 1'b0;
		end else begin
			eng_start <= 1'b0;
			done_reg  <= 1'b0;
			if (state_reg == M_NOM || state_reg == M_READ ||
			    state_reg == M_RWAIT)
				timer_reg <= timer_reg + 31'h00000001;
			case (state_reg)
			M_IDLE: begin
				// Take a command
				if (cmd_valid) begin
					op_reg      <= cmd_op;
					addr_reg    <= cmd_addr;
					step_reg    <= 3'h0;
					first_reg   <= 1'b1;
					timer_reg   <= 31'h00000000;
					timeout_reg <= 1'b0;
					if (step_count(cmd_op) == 3'h0)
						state_reg <= M_READ;
					else
						state_reg <= M_WRITE;
				end
			end
			M_WRITE: begin
				// Launch one command write
				if (eng_idle) begin
					eng_start <= 1'b1;
					eng_write <= 1'b1;
					state_reg <= M_WWAIT;
				end
			end
			M_WWAIT: begin
				// Next step or move on after the last
				if (eng_done) begin
					if (step_reg == step_count(op_reg) - 3'h1) begin
						if (op_reg == `OP_SECTOR_ERASE)
							state_reg <= M_NOM;
						else if (op_reg == `OP_CHIP_ERASE)
							state_reg <= M_READ;
						else if (op_reg == `OP_ID_READ)
							state_reg <= M_READ;
						else
							state_reg <= M_FIN;
					end else begin
						step_reg  <= step_reg + 3'h1;
						state_reg <= M_WRITE;
					end
				end
			end
			M_NOM: begin
				// Wait the nominal sector erase time before polling
				if (timer_reg >= SECTOR_ERASE_NOM_CYC)
					state_reg <= M_READ;
			end
			M_READ: begin
				// One read cycle at the held address
				if (eng_idle) begin
					eng_start <= 1'b1;
					eng_write <= 1'b0;
					state_reg <= M_RWAIT;
				end
			end
			M_RWAIT: begin
				if (eng_done) begin
					result_reg <= eng_rdata;
					if (op_reg == `OP_CHIP_ERASE ||
					    op_reg == `OP_SECTOR_ERASE) begin
						// Busy while the toggle bit changes between reads
						prev_reg  <= eng_rdata;
						first_reg <= 1'b0;
						if (!first_reg && (eng_rdata[`BIT_TOGGLE] ==
						    prev_reg[`BIT_TOGGLE])) begin
							state_reg <= M_FIN;
						end else if (timer_reg >= CHIP_ERASE_MAX_CYC) begin
							timeout_reg <= 1'b1;
							state_reg   <= M_FIN;
						end else begin
							state_reg <= M_READ;
						end
					end else begin
						state_reg <= M_FIN;
					end
				end
			end
			M_FIN: begin
				// Report completion
				done_reg  <= 1'b1;
				state_reg <= M_IDLE;
			end
			default: begin
				state_reg <= M_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Bus cycle engine
	// ****************************************************************
	flash_bus_cycle u_cycle (
		.clk              (clk),
		.reset            (reset),
		.start            (eng_start),
		.is_write         (eng_write),
		.addr             ((state_reg == M_WRITE || state_reg == M_WWAIT) ?
		                   step_word[34:16] : addr_reg),
		.wdata            (step_word[15:0]),
		.idle             (eng_idle),
		.done_reg         (eng_done),
		.rdata_reg        (eng_rdata),
		.flash_addr_reg   (flash_addr),
		.flash_dq_out_reg (flash_dq_out),
		.flash_dq_oe_reg  (flash_dq_oe),
		.flash_dq_in      (flash_dq_in),
		.flash_ce_n_reg   (flash_ce_n),
		.flash_oe_n_reg   (flash_oe_n),
		.flash_we_n_reg   (flash_we_n)
	);

endmodule // flash_erase_host
`default_nettype wire

/* verification/flash_host_monitor.sv */
/* Checker for the flash erase host: strobe spacing, command words and
   bus ownership at the top ports. Assumes one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module flash_host_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic [2:0]  cmd_op,
	input wire logic [18:0] cmd_addr,
	input wire logic        done_reg,
	input wire logic [18:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic        flash_dq_oe,
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n
);
	logic [7:0]  we_high_cnt; // Cycles the write strobe has been high
	logic [7:0]  oe_high_cnt; // Cycles the read strobe has been high
	logic [18:0] taken_addr;  // Address of the last accepted command

	// Saturating high-time counters; start full so reset is no gap
	always_ff @(posedge clk) begin
		if (reset) begin
			we_high_cnt <= 8'hFF;
			oe_high_cnt <= 8'hFF;
			taken_addr  <= 19'h00000;
		end else begin
			if (!flash_we_n)
				we_high_cnt <= 8'h00;
			else if (we_high_cnt != 8'hFF)
				we_high_cnt <= we_high_cnt + 8'h01;
			if (!flash_oe_n)
				oe_high_cnt <= 8'h00;
			else if (oe_high_cnt != 8'hFF)
				oe_high_cnt <= oe_high_cnt + 8'h01;
			if (cmd_valid && cmd_ready)
				taken_addr <= cmd_addr;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_we_gap_min: assert property (
		$fell(flash_we_n) |-> we_high_cnt >= 8'h13)
		else $error("write strobe high time too short");
	a_oe_pulse_min: assert property (
		$fell(flash_oe_n) |-> oe_high_cnt >= 8'h13)
		else $error("read strobe high pulse too short");
	a_chip_final_addr: assert property (
		($rose(flash_we_n) && flash_dq_out == 16'h0010)
		|-> flash_addr == 19'h05555)
		else $error("chip erase word at wrong address");
	a_sector_final_addr: assert property (
		($rose(flash_we_n) && flash_dq_out == 16'h0030)
		|-> flash_addr == taken_addr)
		else $error("sector erase word at wrong address");
	a_write_owns_bus: assert property (
		!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
		else $error("write without bus ownership");
	a_read_frees_bus: assert property (
		!flash_oe_n |-> !flash_dq_oe && !flash_ce_n && flash_we_n)
		else $error("read while host drives data");
	a_poll_addr_hold: assert property (
		(!flash_ce_n && !$past(flash_ce_n)) |-> $stable(flash_addr))
		else $error("address moved inside a bus cycle");
	a_read_addr_cmd: assert property (
		!flash_oe_n |-> flash_addr == taken_addr)
		else $error("read address differs from command address");
	a_write_data_hold: assert property (
		(!flash_we_n && !$past(flash_we_n)) |-> $stable(flash_dq_out))
		else $error("write data moved under write strobe");
	a_idle_strobes: assert property (
		cmd_ready |-> flash_ce_n && flash_oe_n && flash_we_n)
		else $error("strobe active while idle");
	a_done_single: assert property (done_reg |=> !done_reg)
		else $error("done longer than one cycle");
endmodule // flash_host_monitor

bind flash_erase_host flash_host_monitor i_flash_host_monitor (
	.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.cmd_op(cmd_op), .cmd_addr(cmd_addr), .done_reg(done_reg),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
	.flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

/* verification/flash_device_model.sv */
/* Behavioural dual-plane flash: command decode, erase timer, toggle
   status and identification mode. Assumes the host's clock for timing. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Flash device model
// ****************************************************************
module flash_device_model #(
	parameter int          SECT_CYC = 300,      // Sector erase cycles
	parameter int          CHIP_CYC = 900,      // Chip erase cycles
	parameter int          SLOW_CYC = 5000,     // Erase cycles when slow
	parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h0077  // Arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic [18:0] flash_addr,
	input  wire logic [15:0] flash_dq_out,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_we_n,
	output logic      [15:0] flash_dq_in,
	output logic             busy,
	output logic      [1:0]  erase_kind,
	output logic      [18:0] erase_addr
);
	logic        id_mode = 1'b0;      // Off at power-up
	logic        setup   = 1'b0;      // Erase setup word seen
	logic        tgl     = 1'b1;      // Toggle status level
	logic        we_q    = 1'b1;      // Write strobe last cycle
	logic        rd_q    = 1'b0;      // Read active last cycle
	logic [15:0] wd      = 16'h0000;  // Data of the current write
	logic [18:0] wa      = 19'h00000; // Address of the current write
	logic [15:0] last    = 16'h0000;  // Last word driven
	logic [15:0] word;                // Word a read returns
	int          left    = 0;         // Erase cycles remaining
	wire         rd = !flash_ce_n && !flash_oe_n;
	initial erase_kind = 2'h0;
	initial erase_addr = 19'h00000;
	assign busy = left != 0;

	// Read word: codes, erasing-plane status or array data
	always_comb begin
		if (id_mode)
			word = flash_addr[0] ? DEV_CODE : MFR_CODE;
		else if (busy && (erase_kind == 2'h1 ||
			(flash_addr[18:16] == 3'h0) == (erase_addr[18:16] == 3'h0)))
			word = {8'h00, 1'b0, tgl, 3'h0, tgl, 2'h0};
		else
			word = flash_addr[15:0] ^ 16'h5A5A; // Array data
	end
	// Released bus shows the inverse of the last word
	assign flash_dq_in = rd ? word : ~last;

	// Strobe tracking, erase timer and command decode
	always @(posedge clk) begin
		we_q <= flash_we_n;
		rd_q <= rd;
		if (rd)
			last <= word;
		if (rd_q && !rd)
			tgl <= ~tgl; // Each read steps the toggle
		if (!flash_we_n) begin
			wa <= flash_addr;
			wd <= flash_dq_out;
		end
		if (left != 0)
			left <= left - 1; // Internal erase timer
		if (!we_q && flash_we_n) begin
			if (wd == 16'h00F0)
				id_mode <= 1'b0; // Any exit form leaves id mode
			else if (wd == 16'h0090)
				id_mode <= 1'b1;
			else if (wd == 16'h0080)
				setup <= 1'b1;
			else if (setup && (wd == 16'h0010 || wd == 16'h0030)) begin
				setup      <= 1'b0;
				erase_kind <= (wd == 16'h0010) ? 2'h1 : 2'h2;
				erase_addr <= wa;
				left <= slow ? SLOW_CYC :
					(wd == 16'h0010 ? CHIP_CYC : SECT_CYC);
			end
		end
	end
endmodule // flash_device_model
`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for the flash erase host with a flash model.
   Assumes the host constants header on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	failures++; $display("unexpected %s expected %h seen %h", nm, ex, got); \
	end end
// ****************************************************************
// Testbench
// ****************************************************************
module tb;
	logic        clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, slow = 1'b0;
	logic [2:0]  cmd_op = 3'h0;
	logic [18:0] cmd_addr = 19'h00000, flash_addr, erase_addr;
	logic [15:0] result_reg, flash_dq_out, flash_dq_in;
	logic        cmd_ready, done_reg, timeout_reg, flash_dq_oe, busy;
	logic        flash_ce_n, flash_oe_n, flash_we_n;
	logic [1:0]  erase_kind;
	int          failures = 0, checked = 0, cycles = 0;

	flash_erase_host #(.CHIP_ERASE_MAX_CYC(31'd2000),
		.SECTOR_ERASE_NOM_CYC(31'd50)) i_flash_erase_host (
		.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.done_reg(done_reg), .result_reg(result_reg),
		.timeout_reg(timeout_reg), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
	flash_device_model i_flash_device_model (.clk(clk), .slow(slow),
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
		.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in),
		.busy(busy), .erase_kind(erase_kind), .erase_addr(erase_addr));

	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end

	// Report counts and the verdict, then stop
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One command: request, then wait for done under a bound
	task automatic run(input logic [2:0] op, input logic [18:0] addr);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		cmd_op    = op;
		cmd_addr  = addr;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		while (done_reg !== 1'b1 && n < 8000) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("done", 1'b1, done_reg)
	endtask

	// Array after power-up, both codes, exit back to array
	task automatic t_ident();
		run(`OP_ARRAY_READ, 19'h00001);
		`CHK("power-up read", 16'h5A5B, result_reg)
		run(`OP_ID_READ, 19'h00000);
		`CHK("maker code", 16'h00C3, result_reg)
		run(`OP_ID_READ, 19'h00001);
		`CHK("part code", 16'h0077, result_reg)
		run(`OP_ID_EXIT, 19'h00000);
		run(`OP_ARRAY_READ, 19'h41234);
		`CHK("read after exit", 16'h486E, result_reg)
	endtask

	// Sector erase in each plane, end found by toggle polling
	task automatic t_sector();
		logic [18:0] sa [2];
		sa[0] = 19'h30000;
		sa[1] = 19'h02000;
		for (int i = 0; i < 2; i++) begin
			run(`OP_SECTOR_ERASE, sa[i]);
			`CHK("sector kind", 2'h2, erase_kind)
			`CHK("sector addr", sa[i], erase_addr)
			`CHK("sector busy", 1'b0, busy)
			`CHK("sector timeout", 1'b0, timeout_reg)
			`CHK("sector word", sa[i][15:0] ^ 16'h5A5A, result_reg)
		end
	endtask

	// Chip erase, prompt then too slow for the limit
	task automatic t_chip();
		int n;
		run(`OP_CHIP_ERASE, 19'h05555);
		`CHK("chip kind", 2'h1, erase_kind)
		`CHK("chip addr", 19'h05555, erase_addr)
		`CHK("chip timeout", 1'b0, timeout_reg)
		`CHK("chip busy", 1'b0, busy)
		slow = 1'b1;
		run(`OP_CHIP_ERASE, 19'h05555);
		`CHK("slow timeout", 1'b1, timeout_reg)
		slow = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 6000) begin
			@(posedge clk);
			n++;
		end
		`CHK("slow erase end", 1'b0, busy)
		run(`OP_ARRAY_READ, 19'h00010);
		`CHK("read after erase", 16'h5A4A, result_reg)
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		t_ident();
		t_sector();
		t_chip();
		conclude();
	end
endmodule // tb
`default_nettype wire
